//--- verilog/acq_pkg.sv
/*
 * Shared constants and carrier types for the acquisition trigger buffer:
 * register offsets, field positions, reset values, modes and header layout.
 * Assumes a single 100 MHz clock that is also the sampling tick.
 */
package acq_pkg;
   localparam int LOC_W = 18;
   localparam int BUF_W = 10;
   localparam int CNT_W = 11;
   localparam int EVC_W = 24;
   localparam int ADDR_W = 8;
   localparam int ORG_MAX = 10;
   localparam int TRIG_LAT = 3;
   localparam int HDR_WORDS = 4;

   localparam logic [ADDR_W-1:0] OFS_ACQ_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_CONFIG = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_BUF_ORG = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_CUSTOM_SIZE = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_POST_TRIG = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_CHAN_MASK = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_EVENT_COUNT = 8'h1c;
   localparam logic [ADDR_W-1:0] OFS_TIME_STAMP = 8'h20;
   localparam logic [ADDR_W-1:0] OFS_EVENT_DATA = 8'h24;

   localparam int RUN_BIT = 2;
   localparam int CFG_OVERLAP = 0;
   localparam int CFG_COUNT_ALL = 1;
   localparam int CFG_DENSE = 2;
   localparam int CFG_ZLE = 3;
   localparam int HDR_ZLE_BIT = 24;

   localparam logic [1:0] MODE_REG_RUN = 2'h0;
   localparam logic [1:0] MODE_EXT_RUN = 2'h1;
   localparam logic [1:0] MODE_GATE = 2'h2;

   localparam logic [2:0] RST_ACQ_CTRL = 3'h0;
   localparam logic [3:0] RST_CONFIG = 4'h0;
   localparam logic [3:0] RST_BUF_ORG = 4'h0;
   localparam logic [7:0] RST_CHAN_MASK = 8'hff;
   localparam logic [3:0] HDR_TAG = 4'ha;

   typedef enum logic [2:0] {
      ST_STOP = 3'b001,
      ST_FILL = 3'b010,
      ST_POST = 3'b100
   } win_state_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

   typedef struct packed {
      logic valid;
      logic [31:0] pair;
   } sample_in_t;
endpackage : acq_pkg

//--- verilog/acquisition_trigger_buffer.sv
/*
 * Acquisition controller: run/stop and gating, trigger acceptance, time stamp,
 * event counter, multi-buffer sample memory and event header readout.
 * Assumes synchronous inputs, one clock that is the sampling tick, and a host
 * that uses the plain register port with read data one cycle after the strobe.
 */
module acquisition_trigger_buffer
   import acq_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // register port
   input wire reg_req_t req,
   output logic [31:0] rdata,
   // sample stream, two samples per word
   input wire sample_in_t sample_in,
   // front panel and board signals
   input wire logic gate_input,
   input wire logic trigger_input,
   input wire logic front_reset,
   input wire logic [15:0] io_pattern,
   input wire logic [4:0] slot_board_identifier,
   // status
   output logic trigger_output,
   output logic running,
   output logic memory_full
);

   typedef struct packed {
      logic [2:0] ctrl;
      logic [3:0] cfg;
      logic [3:0] org;
      logic [LOC_W-1:0] custom_location_count;
      logic [LOC_W-1:0] post;
      logic [7:0] mask;
      logic run;
      win_state_t st;
      logic [30:0] trigger_time_stamp;
      logic ovf;
      logic [EVC_W-1:0] evcnt;
      logic [LOC_W-1:0] wp;
      logic [LOC_W:0] filled;
      logic [LOC_W:0] postcnt;
      logic half;
      logic [31:0] hold;
      logic [BUF_W-1:0] act;
      logic [BUF_W-1:0] rdb;
      logic [CNT_W-1:0] frozen;
      logic [LOC_W:0] ri;
      logic pend;
      logic [31:0] cap_ttt;
      logic [15:0] cap_pat;
      logic [EVC_W-1:0] cap_ev;
      logic [31:0] pend_ttt;
      logic [15:0] pend_pat;
      logic [EVC_W-1:0] pend_ev;
      logic [TRIG_LAT-1:0] trig_sr;
      logic full;
      logic [31:0] rdata;
   } state_t;

   state_t s_reg;
   state_t s_next;

   logic [31:0] mem [0:(1<<LOC_W)-1];
   logic [31:0] ev_ttt [0:(1<<BUF_W)-1];
   logic [15:0] ev_pat [0:(1<<BUF_W)-1];
   logic [EVC_W-1:0] ev_cnt [0:(1<<BUF_W)-1];
   logic [LOC_W-1:0] ev_start [0:(1<<BUF_W)-1];

   // location mask of one buffer for an organisation code
   function automatic logic [LOC_W-1:0] loc_mask(input logic [3:0] org);
      logic [3:0] o;
      o = (org > 4'(ORG_MAX)) ? 4'(ORG_MAX) : org;
      loc_mask = LOC_W'(({{LOC_W{1'b0}}, 1'b1} << (LOC_W - int'(o))) - 1'b1);
   endfunction : loc_mask

   // first location of a buffer
   function automatic logic [LOC_W-1:0] buf_base(input logic [BUF_W-1:0] idx, input logic [3:0] org);
      logic [3:0] o;
      o = (org > 4'(ORG_MAX)) ? 4'(ORG_MAX) : org;
      buf_base = LOC_W'({{(LOC_W-BUF_W){1'b0}}, idx} << (LOC_W - int'(o)));
   endfunction : buf_base

   logic run_want;
   logic [LOC_W-1:0] bmask;
   logic [CNT_W-1:0] nbuf;
   logic [LOC_W:0] len;
   logic [LOC_W:0] pre;
   logic [LOC_W:0] ev_words;
   logic store;
   logic commit;
   logic in_post;
   logic trig_run;
   logic accept;
   logic freeze;
   logic release_buf;
   logic [LOC_W-1:0] waddr;
   logic [LOC_W-1:0] raddr;
   logic [LOC_W-1:0] start_loc;
   logic [BUF_W-1:0] act_next;

   always_comb begin
      s_next = s_reg;
      bmask = loc_mask(s_reg.org);
      nbuf = CNT_W'(1) << ((s_reg.org > 4'(ORG_MAX)) ? 4'(ORG_MAX) : s_reg.org);
      if (s_reg.custom_location_count == '0 || s_reg.custom_location_count > bmask) begin
         len = {1'b0, bmask} + 1'b1;
      end else begin
         len = {1'b0, s_reg.custom_location_count};
      end
      pre = ({1'b0, s_reg.post} >= len) ? '0 : len - {1'b0, s_reg.post};
      // size in words, no data words when every channel is masked
      ev_words = (LOC_W+1)'(HDR_WORDS) + ((s_reg.mask != '0) ? len : '0);
      run_want = (s_reg.ctrl[1:0] == MODE_EXT_RUN) ? gate_input : s_reg.ctrl[RUN_BIT];
      // gate mode drops samples while the gate is low
      store = s_reg.run && !s_reg.full && sample_in.valid &&
              (s_reg.ctrl[1:0] != MODE_GATE || gate_input);
      // two words form one committed group of four samples
      commit = store && s_reg.half;
      in_post = (s_reg.st == ST_POST);
      trig_run = trigger_input && s_reg.run;
      if (!in_post) begin
         accept = trig_run && !s_reg.full && (s_reg.filled >= pre);
      end else begin
         accept = trig_run && s_reg.cfg[CFG_OVERLAP] && !s_reg.pend && ((s_reg.frozen + 1'b1) < nbuf);
      end
      freeze = commit && in_post && (s_reg.postcnt <= (LOC_W+1)'(2));
      release_buf = req.rd && (req.addr == OFS_EVENT_DATA) && (s_reg.frozen != '0) &&
                    (s_reg.ri == ev_words - 1'b1);
      waddr = buf_base(s_reg.act, s_reg.org) | s_reg.wp;
      start_loc = (s_reg.wp + LOC_W'(2) - LOC_W'(len)) & bmask;
      act_next = (s_reg.act + 1'b1) & BUF_W'(nbuf - 1'b1);
      raddr = buf_base(s_reg.rdb, s_reg.org) |
              ((ev_start[s_reg.rdb] + LOC_W'(s_reg.ri) - LOC_W'(HDR_WORDS)) & bmask);

      // register writes
      if (req.wr) begin
         case (req.addr)
            OFS_ACQ_CTRL: begin
               s_next.ctrl = req.wdata[2:0];
            end
            OFS_CONFIG: begin
               s_next.cfg = req.wdata[3:0];
            end
            OFS_BUF_ORG: begin
               s_next.org = req.wdata[3:0];
            end
            OFS_CUSTOM_SIZE: begin
               s_next.custom_location_count = req.wdata[LOC_W-1:0];
            end
            OFS_POST_TRIG: begin
               s_next.post = req.wdata[LOC_W-1:0];
            end
            OFS_CHAN_MASK: begin
               s_next.mask = req.wdata[7:0];
            end
            default: begin
            end
         endcase
      end

      s_next.trig_sr = {s_reg.trig_sr[TRIG_LAT-2:0], trigger_input};

      s_next.trigger_time_stamp = s_reg.trigger_time_stamp + 1'b1;
      s_next.ovf = s_reg.ovf | (&s_reg.trigger_time_stamp);
      s_next.run = run_want;
      if (run_want && !s_reg.run) begin
         s_next.trigger_time_stamp = '0;
         s_next.ovf = 1'b0;
         s_next.st = ST_FILL;
         s_next.wp = '0;
         s_next.filled = '0;
         s_next.half = 1'b0;
         s_next.pend = 1'b0;
      end else if (!run_want) begin
         s_next.st = ST_STOP;
         s_next.pend = 1'b0;
         s_next.half = 1'b0;
      end
      if (front_reset) begin
         s_next.trigger_time_stamp = '0;
         s_next.ovf = 1'b0;
      end

      // sample writing continues regardless of refused triggers
      if (store && run_want) begin
         if (!s_reg.half) begin
            s_next.hold = sample_in.pair;
            s_next.half = 1'b1;
         end else begin
            s_next.half = 1'b0;
            s_next.wp = (s_reg.wp + LOC_W'(2)) & bmask;
            if (s_reg.filled <= {1'b0, bmask}) begin
               s_next.filled = s_reg.filled + (LOC_W+1)'(2);
            end
            if (in_post) begin
               s_next.postcnt = s_reg.postcnt - (LOC_W+1)'(2);
            end
         end
      end

      if (accept || (trig_run && s_reg.cfg[CFG_COUNT_ALL])) begin
         s_next.evcnt = s_reg.evcnt + 1'b1;
      end
      if (accept && !in_post && run_want) begin
         s_next.st = ST_POST;
         s_next.postcnt = {1'b0, s_reg.post};
         s_next.cap_ttt = {s_reg.ovf, s_reg.trigger_time_stamp};
         s_next.cap_pat = io_pattern;
         s_next.cap_ev = s_next.evcnt;
      end
      // overlapped trigger waits for the current buffer
      if (accept && in_post && run_want) begin
         s_next.pend = 1'b1;
         s_next.pend_ttt = {s_reg.ovf, s_reg.trigger_time_stamp};
         s_next.pend_pat = io_pattern;
         s_next.pend_ev = s_next.evcnt;
      end

      // freeze and move to the next buffer
      if (freeze && run_want) begin
         s_next.act = act_next;
         s_next.wp = '0;
         s_next.filled = '0;
         if (s_reg.pend) begin
            s_next.st = ST_POST;
            s_next.postcnt = {1'b0, s_reg.post};
            s_next.cap_ttt = s_reg.pend_ttt;
            s_next.cap_pat = s_reg.pend_pat;
            s_next.cap_ev = s_reg.pend_ev;
            s_next.pend = 1'b0;
         end else begin
            s_next.st = ST_FILL;
         end
      end

      // readout walk through header then data
      s_next.rdata = '0;
      if (req.rd) begin
         case (req.addr)
            OFS_ACQ_CTRL: begin
               s_next.rdata = {29'h0, s_reg.ctrl};
            end
            OFS_CONFIG: begin
               s_next.rdata = {28'h0, s_reg.cfg};
            end
            OFS_BUF_ORG: begin
               s_next.rdata = {28'h0, s_reg.org};
            end
            OFS_CUSTOM_SIZE: begin
               s_next.rdata = {{(32-LOC_W){1'b0}}, s_reg.custom_location_count};
            end
            OFS_POST_TRIG: begin
               s_next.rdata = {{(32-LOC_W){1'b0}}, s_reg.post};
            end
            OFS_CHAN_MASK: begin
               s_next.rdata = {24'h0, s_reg.mask};
            end
            OFS_STATUS: begin
               s_next.rdata = {5'h0, s_reg.frozen, 13'h0, s_reg.frozen != '0, s_reg.full, s_reg.run};
            end
            OFS_EVENT_COUNT: begin
               s_next.rdata = {8'h0, s_reg.evcnt};
            end
            OFS_TIME_STAMP: begin
               s_next.rdata = {s_reg.ovf, s_reg.trigger_time_stamp};
            end
            OFS_EVENT_DATA: begin
               if (s_reg.frozen != '0) begin
                  case (s_reg.ri)
                     (LOC_W+1)'(0): begin
                        s_next.rdata = {HDR_TAG, 28'(ev_words)};
                     end
                     (LOC_W+1)'(1): begin
                        s_next.rdata = {slot_board_identifier, 2'h0, s_reg.cfg[CFG_ZLE],
                                        ev_pat[s_reg.rdb], s_reg.mask};
                     end
                     (LOC_W+1)'(2): begin
                        s_next.rdata = {8'h0, ev_cnt[s_reg.rdb]};
                     end
                     (LOC_W+1)'(3): begin
                        s_next.rdata = ev_ttt[s_reg.rdb];
                     end
                     default: begin
                        s_next.rdata = mem[raddr];
                     end
                  endcase
                  s_next.ri = release_buf ? '0 : s_reg.ri + 1'b1;
               end
            end
            default: begin
            end
         endcase
      end
      // buffer returns to the pool after its last word
      if (release_buf) begin
         s_next.rdb = (s_reg.rdb + 1'b1) & BUF_W'(nbuf - 1'b1);
      end
      s_next.frozen = s_reg.frozen + CNT_W'(freeze && run_want) - CNT_W'(release_buf);
      s_next.full = (s_next.frozen >= nbuf);
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         s_reg <= '0;
         s_reg.ctrl <= RST_ACQ_CTRL;
         s_reg.cfg <= RST_CONFIG;
         s_reg.org <= RST_BUF_ORG;
         s_reg.mask <= RST_CHAN_MASK;
         s_reg.st <= ST_STOP;
      end else begin
         s_reg <= s_next;
      end
   end

   // sample and per-event memories
   always_ff @(posedge clock) begin
      if (commit && s_next.run) begin
         mem[waddr] <= s_reg.hold;
         mem[waddr | LOC_W'(1)] <= sample_in.pair;
      end
      if (freeze && s_next.run) begin
         ev_ttt[s_reg.act] <= s_reg.cap_ttt;
         ev_pat[s_reg.act] <= s_reg.cap_pat;
         ev_cnt[s_reg.act] <= s_reg.cap_ev;
         ev_start[s_reg.act] <= start_loc;
      end
   end

   assign rdata = s_reg.rdata;
   assign trigger_output = s_reg.trig_sr[TRIG_LAT-1];
   assign running = s_reg.run;
   assign memory_full = s_reg.full;

   a_trig_forward: assert property (@(posedge clock) disable iff (!rst_b)
      ##3 (trigger_output == $past(trigger_input, 3)))
      else $error("trigger output does not follow input after fixed latency");
   a_ext_run: assert property (@(posedge clock) disable iff (!rst_b)
      (s_reg.ctrl[1:0] == MODE_EXT_RUN && gate_input) |=> running)
      else $error("external gate high did not start acquisition");
   a_reg_stop: assert property (@(posedge clock) disable iff (!rst_b)
      (s_reg.ctrl[1:0] == MODE_REG_RUN && !s_reg.ctrl[RUN_BIT]) |=> !running)
      else $error("cleared run bit did not stop acquisition");
   a_stamp_clear: assert property (@(posedge clock) disable iff (!rst_b)
      $rose(running) |-> (s_reg.trigger_time_stamp == '0 && !s_reg.ovf) ##1 (s_reg.trigger_time_stamp == 31'h1))
      else $error("time stamp not cleared and stepping at start");
   a_gate_drop: assert property (@(posedge clock) disable iff (!rst_b)
      (s_reg.ctrl[1:0] == MODE_GATE && s_reg.ctrl[RUN_BIT] && running && !gate_input) |=> $stable(s_reg.wp))
      else $error("sample stored while gate low");
   a_refuse_stop: assert property (@(posedge clock) disable iff (!rst_b)
      (!running || memory_full || (!in_post && s_reg.filled < pre)) |-> !accept)
      else $error("trigger accepted under a refusal cause");
   a_overlap_off: assert property (@(posedge clock) disable iff (!rst_b)
      (in_post && !s_reg.cfg[CFG_OVERLAP]) |-> !accept)
      else $error("overlapped trigger accepted while disabled");
   a_count_accept: assert property (@(posedge clock) disable iff (!rst_b)
      (accept && s_next.run) |=> (s_reg.evcnt == $past(s_reg.evcnt) + 1'b1))
      else $error("event counter did not step on acceptance");
   a_full_hold: assert property (@(posedge clock) disable iff (!rst_b)
      (memory_full && !release_buf) |=> memory_full)
      else $error("memory full released without a readout");
endmodule : acquisition_trigger_buffer

//--- tb/adc_source.sv
/*
 * Stand-in for the converter side: a stream of sample-pair words, one each
 * clock while enabled, with a running count as sample content.
 * Assumes the acquisition block takes one word per clock when valid is high.
 */
module adc_source
   import acq_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // control
   input wire logic enable,
   // sample stream
   output sample_in_t sample_out
);
   timeunit 1ns;
   timeprecision 100ps;

   logic [15:0] count_reg;

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         count_reg <= 16'h0000;
      end else begin
         count_reg <= count_reg + 16'h0001;
      end
   end

   // idle words toggle every cycle so a stale word is never taken for fresh data
   assign sample_out.valid = enable;
   assign sample_out.pair = enable ? {count_reg, count_reg} : ~{count_reg, count_reg};
endmodule : adc_source

//--- tb/testbench.sv
/*
 * Self-checking bench for the acquisition trigger buffer: register port,
 * run control, trigger forwarding and acceptance, event header readout.
 * Assumes the 100 MHz clock is also the sampling tick.
 */
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   import acq_pkg::*;

   logic clock;
   logic rst_b;
   reg_req_t req;
   logic [31:0] rdata;
   sample_in_t sample_in;
   logic src_en;
   logic gate_input;
   logic trigger_input;
   logic front_reset;
   logic [15:0] io_pattern;
   logic trigger_output;
   logic running;
   logic memory_full;
   int fails;
   int cmp_count;
   logic [31:0] rd_val;

   acquisition_trigger_buffer uut (
      .clock(clock),
      .rst_b(rst_b),
      .req(req),
      .rdata(rdata),
      .sample_in(sample_in),
      .gate_input(gate_input),
      .trigger_input(trigger_input),
      .front_reset(front_reset),
      .io_pattern(io_pattern),
      .slot_board_identifier(5'h13),
      .trigger_output(trigger_output),
      .running(running),
      .memory_full(memory_full)
   );

   adc_source source (
      .clock(clock),
      .rst_b(rst_b),
      .enable(src_en),
      .sample_out(sample_in)
   );

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      end
   endtask : check

   task automatic final_report();
      if (fails == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : final_report

   task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      @(posedge clock);
      req.wr <= 1'b1;
      req.addr <= a;
      req.wdata <= d;
      @(posedge clock);
      req.wr <= 1'b0;
   endtask : wr_reg

   task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [31:0] d);
      @(posedge clock);
      req.rd <= 1'b1;
      req.addr <= a;
      @(posedge clock);
      req.rd <= 1'b0;
      #1;
      d = rdata;
   endtask : rd_reg

   task automatic pulse_trigger();
      @(posedge clock);
      trigger_input <= 1'b1;
      @(posedge clock);
      trigger_input <= 1'b0;
   endtask : pulse_trigger

   task automatic test_reset_values();
      rd_reg(OFS_ACQ_CTRL, rd_val);
      check("ctrl reset", rd_val, 32'h0);
      rd_reg(OFS_CHAN_MASK, rd_val);
      check("mask reset", rd_val, 32'h0000_00ff);
      rd_reg(OFS_EVENT_COUNT, rd_val);
      check("count reset", rd_val, 32'h0);
      rd_reg(8'hfc, rd_val);
      check("unmapped read", rd_val, 32'h0);
      rd_reg(OFS_EVENT_DATA, rd_val);
      check("no event data", rd_val, 32'h0);
   endtask : test_reset_values

   task automatic test_trigger_forward();
      @(posedge clock);
      trigger_input <= 1'b1;
      @(posedge clock);
      trigger_input <= 1'b0;
      @(posedge clock);
      #1;
      check("fwd early", {31'h0, trigger_output}, 32'h0);
      @(posedge clock);
      #1;
      check("fwd on time", {31'h0, trigger_output}, 32'h1);
      @(posedge clock);
      #1;
      check("fwd one cycle", {31'h0, trigger_output}, 32'h0);
   endtask : test_trigger_forward

   task automatic test_register_run();
      wr_reg(OFS_ACQ_CTRL, 32'h4);
      @(posedge clock);
      #1;
      check("reg run start", {31'h0, running}, 32'h1);
      rd_reg(OFS_TIME_STAMP, rd_val);
      check("ts cleared at start", rd_val, 32'h1);
      @(posedge clock);
      front_reset <= 1'b1;
      repeat (3) @(posedge clock);
      rd_reg(OFS_TIME_STAMP, rd_val);
      check("ts front reset", rd_val, 32'h0);
      front_reset <= 1'b0;
      wr_reg(OFS_ACQ_CTRL, 32'h0);
      @(posedge clock);
      #1;
      check("reg run stop", {31'h0, running}, 32'h0);
      wr_reg(OFS_ACQ_CTRL, {29'h0, 1'b1, MODE_GATE});
      @(posedge clock);
      #1;
      check("gate mode run", {31'h0, running}, 32'h1);
      wr_reg(OFS_ACQ_CTRL, {29'h0, 1'b0, MODE_GATE});
      @(posedge clock);
      #1;
      check("gate mode stop", {31'h0, running}, 32'h0);
   endtask : test_register_run

   task automatic test_external_run();
      wr_reg(OFS_ACQ_CTRL, {30'h0, MODE_EXT_RUN});
      repeat (2) @(posedge clock);
      check("ext idle", {31'h0, running}, 32'h0);
      gate_input <= 1'b1;
      repeat (2) @(posedge clock);
      #1;
      check("ext start", {31'h0, running}, 32'h1);
      gate_input <= 1'b0;
      repeat (2) @(posedge clock);
      #1;
      check("ext stop", {31'h0, running}, 32'h0);
   endtask : test_external_run

   task automatic test_event_readout();
      logic [31:0] hdr [4];
      wr_reg(OFS_CHAN_MASK, 32'h0);
      wr_reg(OFS_BUF_ORG, 32'h0);
      wr_reg(OFS_CUSTOM_SIZE, 32'h8);
      wr_reg(OFS_POST_TRIG, 32'h2);
      wr_reg(OFS_CONFIG, 32'h0);
      io_pattern <= 16'hbeef;
      src_en <= 1'b1;
      wr_reg(OFS_ACQ_CTRL, 32'h4);
      repeat (40) @(posedge clock);
      pulse_trigger();
      io_pattern <= 16'h1234;
      for (int i = 0; i < 100 && memory_full !== 1'b1; i++) begin
         @(posedge clock);
      end
      check("full after freeze", {31'h0, memory_full}, 32'h1);
      rd_reg(OFS_STATUS, rd_val);
      check("event ready", {31'h0, rd_val[2]}, 32'h1);
      pulse_trigger();
      rd_reg(OFS_EVENT_COUNT, rd_val);
      check("refused not counted", rd_val, 32'h1);
      for (int i = 0; i < 4; i++) begin
         rd_reg(OFS_EVENT_DATA, hdr[i]);
      end
      check("header size", hdr[0], {HDR_TAG, 28'd4});
      check("header board", hdr[1], {5'h13, 2'b00, 1'b0, 16'hbeef, 8'h00});
      check("header count", hdr[2], 32'h1);
      check("header stamp", hdr[3], 32'd40);
      @(posedge clock);
      #1;
      check("freed after read", {31'h0, memory_full}, 32'h0);
      src_en <= 1'b0;
      wr_reg(OFS_ACQ_CTRL, 32'h0);
   endtask : test_event_readout

   task automatic test_count_all();
      wr_reg(OFS_CONFIG, 32'h2);
      // running with no samples, so the trigger is short of pre-trigger
      wr_reg(OFS_ACQ_CTRL, 32'h4);
      pulse_trigger();
      rd_reg(OFS_EVENT_COUNT, rd_val);
      check("count all refused", rd_val, 32'h2);
      wr_reg(OFS_CONFIG, 32'h0);
      pulse_trigger();
      rd_reg(OFS_EVENT_COUNT, rd_val);
      check("count accepted only", rd_val, 32'h2);
      wr_reg(OFS_ACQ_CTRL, 32'h0);
   endtask : test_count_all

   task automatic test_overlap();
      logic [31:0] w;
      wr_reg(OFS_BUF_ORG, 32'h1);
      wr_reg(OFS_POST_TRIG, 32'h6);
      wr_reg(OFS_CONFIG, 32'h1);
      src_en <= 1'b1;
      wr_reg(OFS_ACQ_CTRL, 32'h4);
      repeat (20) @(posedge clock);
      // second trigger lands inside the first window
      trigger_input <= 1'b1;
      repeat (2) @(posedge clock);
      trigger_input <= 1'b0;
      for (int i = 0; i < 100 && memory_full !== 1'b1; i++) begin
         @(posedge clock);
      end
      check("overlap fills both", {31'h0, memory_full}, 32'h1);
      for (int i = 0; i < 8; i++) begin
         rd_reg(OFS_EVENT_DATA, w);
         if (i % 4 == 2) begin
            check("overlap count", w, 32'(3 + i / 4));
         end
      end
      src_en <= 1'b0;
      wr_reg(OFS_ACQ_CTRL, 32'h0);
   endtask : test_overlap

   initial begin
      fails = 0;
      cmp_count = 0;
      rst_b = 1'b0;
      req = '0;
      src_en = 1'b0;
      gate_input = 1'b0;
      trigger_input = 1'b0;
      front_reset = 1'b0;
      io_pattern = 16'h0000;
      repeat (20) @(posedge clock);
      rst_b <= 1'b1;
      test_reset_values();
      test_trigger_forward();
      test_register_run();
      test_external_run();
      test_event_readout();
      test_count_all();
      test_overlap();
      final_report();
   end

   // watchdog well beyond the few hundred cycles the tests need
   initial begin
      #200000;
      fails++;
      final_report();
   end
endmodule : testbench
